// ---- rtl/pwm_ctrl.sv ----
// Time base, special event and generator control of the PWM unit
`timescale 1ns/1ps
module pwm_ctrl
    import pwm_ctrl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire bus_req_t    bus_req,
    output logic [15:0]      rd_data,
    input  wire logic        idle_mode,
    input  wire logic        sync_in_one,
    input  wire logic        sync_in_two,
    input  wire gen_event_t  gen_event,
    input  wire logic        special_event_ack,
    output logic             sync_out,
    output logic             sync_out_en,
    output logic             special_event_trigger,
    output logic             special_event_irq,
    output logic             generator_irq,
    output logic             pwm_high,
    output logic             pwm_low,
    output logic [1:0]       dead_time_mode,
    output logic             center_aligned_active
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] tbc;
        logic [2:0]  prescale;
        logic [15:0] period;
        logic [15:0] period_act;
        logic [12:0] cmp;
        logic [15:0] mdc;
        logic [15:0] gcon;
        logic [15:0] phase;
        logic [15:0] pdc;
        logic [15:0] sdc;
        logic [15:0] duty_act;
        logic [15:0] sduty_act;
        logic        sev_pend;
        logic [3:0]  ps_cnt;
        logic [5:0]  div_cnt;
        logic [15:0] mcnt;
        logic [15:0] gcnt;
        logic        gdown;
        logic [2:0]  gflags;
        logic        sync_prev;
        logic [15:0] rd_data;
        logic        sync_out;
        logic        sync_oe;
        logic        sev_trig;
        logic        sev_irq;
        logic        gen_irq;
        logic        pwm_high;
        logic        pwm_low;
        logic [1:0]  dt_mode;
        logic        ca_active;
    } state_t;

    state_t      st_r;
    state_t      st_nxt;
    logic [1:0]  rst_sync_r;
    logic        rst_n_int;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync_r[1];

    // ------------------------------------------------------------------
    // Duty limiting
    // ------------------------------------------------------------------
    function automatic logic [15:0] limit_duty(input logic [15:0] d, input logic [15:0] p);
        logic [15:0] hi;
        logic [15:0] r;
        hi = p - DUTY_TOP_GAP;
        r  = d;
        if (r < DUTY_MIN) begin
            r = DUTY_MIN;
        end
        if (r > hi) begin
            r = hi;
        end
        if ((r < DUTY_MIN + DEGRADE_SPAN) || (r + DEGRADE_SPAN > hi)) begin
            r = {r[15:2], 2'h0};
        end
        // Rounding must not undercut the smallest pulse
        if (r < DUTY_MIN) begin
            r = DUTY_MIN;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic        running;
    logic        tick;
    logic [5:0]  div_mask;
    logic        sync_raw;
    logic        sync_asserted;
    logic        sync_edge;
    logic        m_bnd;
    logic        g_bnd;
    logic        independent_period_sel;
    logic        center;
    logic [15:0] g_period;
    logic [15:0] duty_src;
    logic [15:0] sduty_src;
    logic        match;
    logic        sev_fire;
    logic        wr_tbc;
    logic        wr_gc;
    logic [2:0]  gen_ev;
    logic [2:0]  gen_en;

    always_comb begin
        st_nxt   = st_r;
        running  = st_r.tbc[TBC_MODULE_ON];
        div_mask = 6'h0;
        tick     = 1'b0;
        m_bnd    = 1'b0;
        g_bnd    = 1'b0;
        match    = 1'b0;
        sev_fire = 1'b0;
        independent_period_sel      = st_r.gcon[GC_INDEP_PERIOD];
        center   = independent_period_sel & st_r.gcon[GC_CENTER_ON];
        g_period = independent_period_sel ? st_r.phase : st_r.period_act;
        duty_src = st_r.gcon[GC_MASTER_DUTY] ? st_r.mdc : st_r.pdc;
        sduty_src = st_r.gcon[GC_MASTER_DUTY] ? st_r.mdc : st_r.sdc;
        wr_tbc   = bus_req.wr && (bus_req.addr == OFS_TIME_BASE_CONTROL);
        wr_gc    = bus_req.wr && (bus_req.addr == OFS_GENERATOR_CONTROL);
        gen_ev   = {gen_event.fault, gen_event.curlimit, gen_event.trigger};
        gen_en   = st_r.gcon[GC_FAULT_IRQ_ON:GC_TRIG_IRQ_ON];

        // Sync input selection and polarity
        sync_raw = (st_r.tbc[TBC_SYNC_SRC_LO +: 2] == 2'h1) ? sync_in_two
                 : (st_r.tbc[TBC_SYNC_SRC_LO +: 2] == 2'h0) ? sync_in_one : 1'b0;
        sync_asserted = sync_raw ^ st_r.tbc[TBC_SYNC_POLARITY];
        sync_edge = sync_asserted & ~st_r.sync_prev;
        st_nxt.sync_prev = sync_asserted;

        // Prescaler
        case (st_r.prescale)
            3'h0:    div_mask = 6'h00;
            3'h1:    div_mask = 6'h01;
            3'h2:    div_mask = 6'h03;
            3'h3:    div_mask = 6'h07;
            3'h4:    div_mask = 6'h0f;
            3'h5:    div_mask = 6'h1f;
            3'h6:    div_mask = 6'h3f;
            default: div_mask = 6'h00;
        endcase
        if (!running || (st_r.tbc[TBC_IDLE_STOP] && idle_mode)) begin
            st_nxt.div_cnt = 6'h0;
        end else if (st_r.prescale != PRESCALE_RESERVED) begin
            if (st_r.div_cnt >= div_mask) begin
                st_nxt.div_cnt = 6'h0;
                tick = 1'b1;
            end else begin
                st_nxt.div_cnt = st_r.div_cnt + 6'h1;
            end
        end

        // Master time base
        if (!running) begin
            st_nxt.mcnt = 16'h0;
            st_nxt.ps_cnt = 4'h0;
        end else if (st_r.tbc[TBC_EXT_SYNC_ON] && sync_edge) begin
            st_nxt.mcnt = 16'h0;
            m_bnd = 1'b1;
        end else if (tick) begin
            match = (st_r.mcnt == {st_r.cmp, 3'h0});
            if (st_r.mcnt >= st_r.period_act) begin
                st_nxt.mcnt = 16'h0;
                m_bnd = 1'b1;
            end else begin
                st_nxt.mcnt = st_r.mcnt + 16'h1;
            end
        end

        // Special event postscaler
        if (match) begin
            if (st_r.ps_cnt >= st_r.tbc[TBC_SEV_PS_LO +: 4]) begin
                st_nxt.ps_cnt = 4'h0;
                sev_fire = 1'b1;
            end else begin
                st_nxt.ps_cnt = st_r.ps_cnt + 4'h1;
            end
        end
        st_nxt.sev_trig = sev_fire;
        if (sev_fire) begin
            st_nxt.sev_pend = 1'b1;
        end else if (special_event_ack) begin
            st_nxt.sev_pend = 1'b0;
        end
        st_nxt.sev_irq = st_nxt.sev_pend & st_r.tbc[TBC_SEV_IRQ_ON];

        // Active period
        if (m_bnd) begin
            st_nxt.period_act = st_r.period;
        end

        // Generator time base
        if (!running) begin
            st_nxt.gcnt = 16'h0;
            st_nxt.gdown = 1'b0;
        end else if (!independent_period_sel) begin
            st_nxt.gcnt = st_nxt.mcnt;
            g_bnd = m_bnd;
        end else if (tick) begin
            if (center) begin
                if (st_r.gdown) begin
                    if (st_r.gcnt == 16'h0) begin
                        st_nxt.gdown = 1'b0;
                        g_bnd = 1'b1;
                    end else begin
                        st_nxt.gcnt = st_r.gcnt - 16'h1;
                    end
                end else if (st_r.gcnt >= g_period) begin
                    st_nxt.gdown = 1'b1;
                end else begin
                    st_nxt.gcnt = st_r.gcnt + 16'h1;
                end
            end else if (st_r.gcnt >= g_period) begin
                st_nxt.gcnt = 16'h0;
                st_nxt.gdown = 1'b0;
                g_bnd = 1'b1;
            end else begin
                st_nxt.gcnt = st_r.gcnt + 16'h1;
            end
        end

        // Active duty
        if (st_r.gcon[GC_IMM_DUTY_UPD] || g_bnd) begin
            st_nxt.duty_act = duty_src;
            st_nxt.sduty_act = sduty_src;
        end

        // Generator pending flags
        // Event in the clearing cycle wins
        for (int i = 0; i < 3; i++) begin
            if (gen_ev[i]) begin
                st_nxt.gflags[i] = 1'b1;
            end else if (wr_gc && !bus_req.wdata[GC_TRIG_IRQ_ON + i]) begin
                st_nxt.gflags[i] = 1'b0;
            end
        end
        st_nxt.gen_irq = |(st_nxt.gflags & gen_en);

        // Outputs
        st_nxt.pwm_high = running && (st_nxt.gcnt < limit_duty(st_nxt.duty_act, g_period));
        st_nxt.pwm_low  = running && (st_nxt.gcnt < limit_duty(st_nxt.sduty_act, g_period));
        st_nxt.sync_oe  = running && st_r.tbc[TBC_SYNC_OUT_ON];
        st_nxt.sync_out = (running && st_r.tbc[TBC_SYNC_OUT_ON] && m_bnd)
                          ^ st_r.tbc[TBC_SYNC_POLARITY];
        st_nxt.dt_mode  = (st_r.gcon[GC_DEAD_TIME_LO +: 2] == DT_RESERVED)
                          ? DT_DISABLED : st_r.gcon[GC_DEAD_TIME_LO +: 2];
        st_nxt.ca_active = running && center;

        // Register writes
        // Pending bits kept out by the write masks
        if (bus_req.wr) begin
            case (bus_req.addr)
                OFS_TIME_BASE_CONTROL: st_nxt.tbc = bus_req.wdata & TBC_WR_MASK;
                OFS_CLOCK_DIVIDER_SEL: st_nxt.prescale = bus_req.wdata[2:0];
                OFS_MASTER_PERIOD: begin
                    st_nxt.period = bus_req.wdata;
                    if (st_r.tbc[TBC_IMM_PERIOD_UPD]) begin
                        st_nxt.period_act = bus_req.wdata;
                    end
                end
                OFS_SPECIAL_EVT_CMP:   st_nxt.cmp = bus_req.wdata[15:3];
                OFS_MASTER_DUTY_CYCLE: st_nxt.mdc = bus_req.wdata;
                OFS_GENERATOR_CONTROL: st_nxt.gcon = bus_req.wdata & GC_WR_MASK;
                OFS_PRIMARY_PHASE:     st_nxt.phase = bus_req.wdata;
                OFS_PRIMARY_DUTY:      st_nxt.pdc = bus_req.wdata;
                OFS_SECONDARY_DUTY:    st_nxt.sdc = bus_req.wdata;
                default: ;
            endcase
        end
        // Switching off loads a waiting period
        if (wr_tbc && !st_r.tbc[TBC_IMM_PERIOD_UPD] && !bus_req.wdata[TBC_MODULE_ON]) begin
            st_nxt.period_act = st_nxt.period;
        end

        // Register reads
        st_nxt.rd_data = 16'h0;
        if (bus_req.rd) begin
            case (bus_req.addr)
                OFS_TIME_BASE_CONTROL: begin
                    st_nxt.rd_data = st_r.tbc;
                    st_nxt.rd_data[TBC_SEV_PENDING] = st_r.sev_pend;
                end
                OFS_CLOCK_DIVIDER_SEL: st_nxt.rd_data = {13'h0, st_r.prescale};
                OFS_MASTER_PERIOD:     st_nxt.rd_data = st_r.period;
                OFS_SPECIAL_EVT_CMP:   st_nxt.rd_data = {st_r.cmp, 3'h0};
                OFS_MASTER_DUTY_CYCLE: st_nxt.rd_data = st_r.mdc;
                OFS_GENERATOR_CONTROL: st_nxt.rd_data = {st_r.gflags, st_r.gcon[12:0]};
                OFS_PRIMARY_PHASE:     st_nxt.rd_data = st_r.phase;
                OFS_PRIMARY_DUTY:      st_nxt.rd_data = st_r.pdc;
                OFS_SECONDARY_DUTY:    st_nxt.rd_data = st_r.sdc;
                OFS_MASTER_TIME_CNT:   st_nxt.rd_data = st_r.mcnt;
                default:               st_nxt.rd_data = 16'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            st_r            <= '0;
            st_r.prescale   <= PRESCALE_RST;
            st_r.period     <= MASTER_PERIOD_RST;
            st_r.period_act <= MASTER_PERIOD_RST;
            st_r.sync_prev  <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data               = st_r.rd_data;
    assign sync_out              = st_r.sync_out;
    assign sync_out_en           = st_r.sync_oe;
    assign special_event_trigger = st_r.sev_trig;
    assign special_event_irq     = st_r.sev_irq;
    assign generator_irq         = st_r.gen_irq;
    assign pwm_high              = st_r.pwm_high;
    assign pwm_low               = st_r.pwm_low;
    assign dead_time_mode        = st_r.dt_mode;
    assign center_aligned_active = st_r.ca_active;

endmodule // pwm_ctrl

// ---- rtl/pwm_ctrl_pkg.sv ----
// Package with register map, field positions, reset values and carrier types
package pwm_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_TIME_BASE_CONTROL = 8'h00;
    localparam logic [7:0]  OFS_CLOCK_DIVIDER_SEL = 8'h04;
    localparam logic [7:0]  OFS_MASTER_PERIOD     = 8'h08;
    localparam logic [7:0]  OFS_SPECIAL_EVT_CMP   = 8'h0c;
    localparam logic [7:0]  OFS_MASTER_DUTY_CYCLE = 8'h10;
    localparam logic [7:0]  OFS_GENERATOR_CONTROL = 8'h14;
    localparam logic [7:0]  OFS_PRIMARY_PHASE     = 8'h18;
    localparam logic [7:0]  OFS_PRIMARY_DUTY      = 8'h1c;
    localparam logic [7:0]  OFS_SECONDARY_DUTY    = 8'h20;
    localparam logic [7:0]  OFS_MASTER_TIME_CNT   = 8'h24;

    // ------------------------------------------------------------------
    // Time base control field positions
    // ------------------------------------------------------------------
    localparam int TBC_MODULE_ON      = 15;
    localparam int TBC_IDLE_STOP      = 13;
    localparam int TBC_SEV_PENDING    = 12;
    localparam int TBC_SEV_IRQ_ON     = 11;
    localparam int TBC_IMM_PERIOD_UPD = 10;
    localparam int TBC_SYNC_POLARITY  = 9;
    localparam int TBC_SYNC_OUT_ON    = 8;
    localparam int TBC_EXT_SYNC_ON    = 7;
    localparam int TBC_SYNC_SRC_LO    = 4;
    localparam int TBC_SEV_PS_LO      = 0;
    localparam logic [15:0] TBC_WR_MASK = 16'hafbf;

    // ------------------------------------------------------------------
    // Generator control field positions
    // ------------------------------------------------------------------
    localparam int GC_FAULT_PEND   = 15;
    localparam int GC_CURLIM_PEND  = 14;
    localparam int GC_TRIG_PEND    = 13;
    localparam int GC_FAULT_IRQ_ON = 12;
    localparam int GC_CURLIM_IRQ_ON = 11;
    localparam int GC_TRIG_IRQ_ON  = 10;
    localparam int GC_INDEP_PERIOD = 9;
    localparam int GC_MASTER_DUTY  = 8;
    localparam int GC_DEAD_TIME_LO = 6;
    localparam int GC_CENTER_ON    = 2;
    localparam int GC_IMM_DUTY_UPD = 0;
    localparam logic [15:0] GC_WR_MASK = 16'h1fc7;

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [15:0] MASTER_PERIOD_RST = 16'hfff8;
    localparam logic [2:0]  PRESCALE_RST      = 3'h0;
    localparam logic [2:0]  PRESCALE_RESERVED = 3'h7;
    localparam logic [15:0] DUTY_MIN          = 16'h0009;
    localparam logic [15:0] DUTY_TOP_GAP      = 16'h0008;
    localparam logic [15:0] DEGRADE_SPAN      = 16'h0010;
    localparam logic [1:0]  DT_DISABLED       = 2'h2;
    localparam logic [1:0]  DT_RESERVED       = 2'h3;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        logic fault;
        logic curlimit;
        logic trigger;
    } gen_event_t;

endpackage

// ---- tb/pwm_ctrl_asserts.sv ----
// Port-level assertions for the PWM control block
`timescale 1ns/1ps
module pwm_ctrl_asserts
    import pwm_ctrl_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire bus_req_t   bus_req,
    input wire gen_event_t gen_event,
    input wire logic       sync_out_en,
    input wire logic       special_event_trigger,
    input wire logic       special_event_irq,
    input wire logic       generator_irq,
    input wire logic [1:0] dead_time_mode,
    input wire logic       center_aligned_active
);
    // ------------------------------------------------------------------
    // Write decodes and checks
    // ------------------------------------------------------------------
    logic tb_wr;
    logic gc_wr;
    assign tb_wr = bus_req.wr && (bus_req.addr == OFS_TIME_BASE_CONTROL);
    assign gc_wr = bus_req.wr && (bus_req.addr == OFS_GENERATOR_CONTROL);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_dt_no_reserved: assert property (dead_time_mode != 2'h3)
        else $error("dead time mode shows reserved code");
    a_dt_follows_wr: assert property (gc_wr |-> ##2 dead_time_mode ==
        (($past(bus_req.wdata[7:6], 2) == 2'h3) ? 2'h2 : $past(bus_req.wdata[7:6], 2)))
        else $error("dead time mode not taken from write");
    a_center_needs_itb: assert property (gc_wr && !bus_req.wdata[9] |-> ##2 !center_aligned_active)
        else $error("center mode active without independent period");
    a_center_needs_on: assert property (tb_wr && !bus_req.wdata[15] |-> ##2 !center_aligned_active)
        else $error("center mode active while module off");
    a_sync_oe_follows: assert property (tb_wr |-> ##2 sync_out_en ==
        $past(bus_req.wdata[15] && bus_req.wdata[8], 2))
        else $error("sync output enable wrong");
    a_seirq_gated: assert property (tb_wr && !bus_req.wdata[11] |-> ##2 !special_event_irq [*3])
        else $error("special event irq while disabled");
    a_gen_irq_clear: assert property (gc_wr && bus_req.wdata[12:10] == 3'h0 |-> ##2 !generator_irq)
        else $error("generator irq after enables cleared");
    a_gen_irq_cause: assert property ($rose(generator_irq) |-> $past(|gen_event) || $past(gc_wr, 2))
        else $error("generator irq without event");
    a_trig_one_cycle: assert property (special_event_trigger |=> !special_event_trigger)
        else $error("special event trigger longer than one cycle");
endmodule  // pwm_ctrl_asserts

bind pwm_ctrl pwm_ctrl_asserts i_pwm_ctrl_asserts (
    .clk(clk), .reset_n(reset_n), .bus_req(bus_req), .gen_event(gen_event),
    .sync_out_en(sync_out_en), .special_event_trigger(special_event_trigger),
    .special_event_irq(special_event_irq), .generator_irq(generator_irq),
    .dead_time_mode(dead_time_mode), .center_aligned_active(center_aligned_active)
);

// ---- tb/pwm_ctrl_tb.sv ----
// Self-checking bench for the PWM time base and generator control block
`timescale 1ns/1ps
module pwm_ctrl_tb;
    import pwm_ctrl_pkg::*;
    localparam logic [7:0] A_TB = OFS_TIME_BASE_CONTROL;
    localparam logic [7:0] A_GC = OFS_GENERATOR_CONTROL;
    localparam logic [7:0] A_CNT = OFS_MASTER_TIME_CNT;
    localparam logic [7:0] A_PER = OFS_MASTER_PERIOD;
    logic        clk, reset_n, idle_mode, special_event_ack, act_low, fire_one, fire_two;
    logic        sync_in_one, sync_in_two, sync_out, sync_out_en, special_event_trigger;
    logic        special_event_irq, generator_irq, pwm_high, pwm_low, center_aligned_active;
    logic [1:0]  dead_time_mode;
    logic [15:0] rd_data, v, w;
    bus_req_t    bus_req;
    gen_event_t  gen_event;
    int          n;
    int          num_errors = 0;
    int          comparisons = 0;
    logic [7:0]  ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h24};
    logic [15:0] rv[7] = '{16'h0, 16'h0, 16'hfff8, 16'h0, 16'h0, 16'h0, 16'h0};
    logic [7:0]  ma[4] = '{8'h00, 8'h04, 8'h0c, 8'h14};
    logic [15:0] mw[4] = '{16'h7fff, 16'hffff, 16'hffff, 16'hffff};
    logic [15:0] me[4] = '{16'h2fbf, 16'h0007, 16'hfff8, 16'h1fc7};
    logic [3:0]  ps[4] = '{4'h0, 4'h1, 4'h3, 4'hf};
    logic [15:0] gv[3] = '{16'h0105, 16'h0201, 16'h0205};
    int          gn[3] = '{65, 33, 66};
    logic [15:0] gh[3] = '{16'h0009, 16'h0014, 16'h0028};
    logic [15:0] gl[3] = '{16'h0009, 16'h0010, 16'h0020};

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    pwm_ctrl i_pwm_ctrl (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data),
        .idle_mode(idle_mode), .sync_in_one(sync_in_one), .sync_in_two(sync_in_two),
        .gen_event(gen_event), .special_event_ack(special_event_ack), .sync_out(sync_out),
        .sync_out_en(sync_out_en), .special_event_trigger(special_event_trigger),
        .special_event_irq(special_event_irq), .generator_irq(generator_irq),
        .pwm_high(pwm_high), .pwm_low(pwm_low), .dead_time_mode(dead_time_mode),
        .center_aligned_active(center_aligned_active));
    sync_source_model i_sync_source_model (.clk(clk), .active_low(act_low),
        .fire_one(fire_one), .fire_two(fire_two), .sync_in_one(sync_in_one),
        .sync_in_two(sync_in_two));

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 v = rd_data;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        rd(a);
        chk(v, e);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Cycles until the chosen output next shows its active level
    task automatic await_pulse(input logic trig, input logic act, output int cyc);
        cyc = 0;
        do begin
            @(posedge clk);
            #1;
            cyc++;
        end while ((trig ? special_event_trigger : sync_out) !== act && cyc < 2400);
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        bus_req = '0;
        idle_mode = 1'b0;
        gen_event = '0;
        special_event_ack = 1'b0;
        act_low = 1'b0;
        fire_one = 1'b0;
        fire_two = 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        foreach (ra[i]) rdc(ra[i], rv[i]);
        foreach (ma[i]) begin
            wr(ma[i], mw[i]);
            rdc(ma[i], me[i]);
        end
        wr(8'h28, 16'hffff);
        rdc(8'h28, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            wr(A_GC, 16'(c << 6));
            settle();
            chk(16'(dead_time_mode), (c == 3) ? 16'h2 : 16'(c));
        end
        wr(A_PER, 16'h0010);
        for (int c = 0; c < 7; c++) begin
            wr(A_TB, 16'h0000);
            wr(OFS_CLOCK_DIVIDER_SEL, 16'(c));
            wr(A_TB, c[0] ? 16'h8300 : 16'h8100);
            settle();
            chk(16'(sync_out), 16'(c[0]));
            chk(16'(sync_out_en), 16'h0001);
            await_pulse(1'b0, ~c[0], n);
            await_pulse(1'b0, ~c[0], n);
            chk(16'(n), 16'(17 << c));
        end
        wr(A_TB, 16'h0000);
        wr(OFS_CLOCK_DIVIDER_SEL, 16'h0000);
        for (int s = 0; s < 2; s++) begin
            wr(A_TB, s ? 16'ha000 : 16'h8000);
            idle_mode <= 1'b1;
            rd(A_CNT);
            w = v;
            rd(A_CNT);
            chk(16'(v == w), 16'(s));
            @(posedge clk);
            idle_mode <= 1'b0;
        end
        for (int s = 0; s < 2; s++) begin
            wr(A_TB, 16'h0000);
            wr(A_TB, s ? 16'h8500 : 16'h8100);
            wr(A_PER, 16'h0010);
            await_pulse(1'b0, 1'b1, n);
            await_pulse(1'b0, 1'b1, n);
            wr(A_PER, 16'h0020);
            await_pulse(1'b0, 1'b1, n);
            chk(16'(n > 20), 16'(s));
        end
        wr(A_PER, 16'h0040);
        for (int s = 0; s < 3; s++) begin
            wr(A_TB, 16'h0000);
            act_low <= (s == 1);
            wr(A_TB, 16'h8180 | 16'(s << 4) | ((s == 1) ? 16'h0200 : 16'h0000));
            await_pulse(1'b0, s != 1, n);
            repeat (30) @(posedge clk);
            fire_one <= (s != 1);
            fire_two <= (s != 0);
            @(posedge clk);
            fire_one <= 1'b0;
            fire_two <= 1'b0;
            rd(A_CNT);
            chk(16'(v < 16'h0010), 16'(s < 2));
        end
        wr(A_PER, 16'h0010);
        wr(OFS_SPECIAL_EVT_CMP, 16'h0008);
        foreach (ps[i]) begin
            wr(A_TB, 16'h0000);
            wr(A_TB, 16'h8800 | 16'(ps[i]));
            await_pulse(1'b1, 1'b1, n);
            await_pulse(1'b1, 1'b1, n);
            chk(16'(n), 16'(17 * (ps[i] + 1)));
            settle();
            chk(16'(special_event_irq), 16'h0001);
            rdc(A_TB, 16'h9800 | 16'(ps[i]));
            @(posedge clk);
            special_event_ack <= 1'b1;
            @(posedge clk);
            special_event_ack <= 1'b0;
            settle();
            chk(16'(special_event_irq), 16'h0000);
        end
        for (int e = 0; e < 3; e++) begin
            wr(A_GC, 16'h1c00);
            gen_event <= gen_event_t'(3'b100 >> e);
            @(posedge clk);
            gen_event <= '0;
            settle();
            chk(16'(generator_irq), 16'h0001);
            rdc(A_GC, 16'h1c00 | (16'h8000 >> e));
            wr(A_GC, 16'h1c00 ^ (16'h1000 >> e));
            settle();
            chk(16'(generator_irq), 16'h0000);
            rdc(A_GC, 16'h1c00 ^ (16'h1000 >> e));
        end
        wr(A_PER, 16'h0040);
        wr(OFS_MASTER_DUTY_CYCLE, 16'h0000);
        wr(OFS_PRIMARY_PHASE, 16'h0020);
        wr(OFS_PRIMARY_DUTY, 16'h0017);
        wr(OFS_SECONDARY_DUTY, 16'h0012);
        for (int s = 0; s < 3; s++) begin
            wr(A_TB, 16'h0000);
            wr(A_GC, gv[s]);
            wr(A_TB, 16'h8000);
            n = 0;
            w = 16'h0;
            repeat (gn[s]) begin
                @(posedge clk);
                #1;
                n += int'(pwm_high);
                w += 16'(pwm_low);
            end
            chk(16'(n), gh[s]);
            chk(w, gl[s]);
            chk(16'(center_aligned_active), 16'(s == 2));
        end
        tally_and_finish();
    end

    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
endmodule  // pwm_ctrl_tb

// ---- tb/sync_source_model.sv ----
// Far-side model of the external sync sources
`timescale 1ns/1ps
module sync_source_model (
    input  wire logic clk,
    input  wire logic active_low,
    input  wire logic fire_one,
    input  wire logic fire_two,
    output logic      sync_in_one,
    output logic      sync_in_two
);
    // Idles at the inactive level, one active cycle per request
    always @(posedge clk) begin
        sync_in_one <= active_low ^ fire_one;
        sync_in_two <= active_low ^ fire_two;
    end
endmodule  // sync_source_model
